// ==== pkg/adcp_defs.svh ====
// Field positions, reset values, limits and word lengths of the DAC control port
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH
// Mode control register field positions
`define ADCP_B_ATT_N    7
`define ADCP_B_DUAL_N   6
`define ADCP_B_SIL_N    5
`define ADCP_B_EMPH     4
`define ADCP_B_FULL     3
`define ADCP_B_UP       2
`define ADCP_B_DOWN     1
`define ADCP_B_RSVD     0
// Reset value: no attenuation, normal speed, no mute, no emphasis
`define ADCP_MODE_RST   8'hE0
// Synchroniser reset: pins 2 and 1 at their idle high level, so no false edge follows reset
`define ADCP_PIN_RST    6'h03
// Fade counter limits
`define ADCP_FADE_MAX   7'h78
`define ADCP_FADE_ATT   7'h1E
`define ADCP_FADE_MIN   7'h00
// Word lengths per format code
`define ADCP_LEN_I2S    5'h14
`define ADCP_LEN_16     5'h10
`define ADCP_LEN_18     5'h12
`define ADCP_LEN_20     5'h14
`endif

// ==== pkg/adcp_pkg.sv ====
// Types of the DAC control port
`default_nettype none
package adcp_pkg;
   // Control method selected by the select pin and application pin 3
   typedef enum logic [2:0] {
      ADCP_ST_STATIC = 3'b001,
      ADCP_ST_SERIAL = 3'b010,
      ADCP_ST_IDLE   = 3'b100
   } adcp_mode_e;
   typedef logic [6:0] adcp_fade_t;
endpackage
`default_nettype wire

// ==== hdl/adcp_top.sv ====
// Control front end of a stereo audio DAC: format pins, static pins, serial mode port
`timescale 1ns/1ns
`default_nettype none
`include "adcp_defs.svh"

// Function
// - Format pins: 00 two-channel bus, 01/10/11 right-justified 16/18/20 bits.
// - Two-channel bus up to 20 bits; right-justified length from format pins.
// - Left and right words share one data line, one after the other.
// - Select high, pin 3 low: serial port; select low: four static pins.
// - Static pin 0 low attenuates 12 dB, high full scale, only unmuted.
// - Static pin 1 low double speed, high normal speed.
// - Static pin 2 low ramps to mute, high follows attenuation.
// - Static pin 3 high enables emphasis filter, low disables it.
// - Serial mode: 8-bit register, pin 0 data, pin 1 clock, pin 2 strobe.
// - Data sampled on rising shift clock, most significant bit first.
// - Strobe rising with shift clock high loads the upper seven bits into register; bit 0 is cleared.
// - More than eight bits shifted: only the last eight are kept.
// - Strobe rising with shift clock low discards the command.
// - Repeated strobe pulses re-execute last command; clock stays high.
// - Bits: att, speed, mute active low; emph, full, up, down high.
// - Counter 0..120; full presets 120, mute 0, attenuate 30 if above.
// - Each step-up or step-down write moves the counter by one, holding at 120 and at 0.
// - Mute wins over attenuation.
// - Level and emphasis changes apply only at sample word boundaries.
module adcp_top
   import adcp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Format and method pins
   input  wire logic        format_select_hi,
   input  wire logic        format_select_lo,
   input  wire logic        interface_select,
   // Application pins
   input  wire logic        ctrl_pin_0,
   input  wire logic        ctrl_pin_1,
   input  wire logic        ctrl_pin_2,
   input  wire logic        ctrl_pin_3,
   // Word boundary pulse from the audio receiver, same clock
   input  wire logic        word_boundary,
   // Format results
   output logic             right_justified,
   output logic [4:0]       word_bits,
   // Level and filter controls
   output logic             dual_rate,
   output logic             emphasis_filter_on,
   output logic [6:0]       fade_count,
   output logic             serial_active,
   output logic [7:0]       playback_mode_control
);

   // Two-stage synchronisers for the six pins, plus an edge history stage
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic [5:0] old_q;
   logic [5:0] pins;
   assign pins = {format_select_hi, format_select_lo, interface_select,
                  ctrl_pin_3, ctrl_pin_2, ctrl_pin_1};
   logic       d0_meta_q;
   logic       d0_sync_q;

   // Pins are asynchronous to clk; only the second stage is read
   // Reset to the idle pin levels so the edge detectors see no false edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q    <= `ADCP_PIN_RST;
         sync_q    <= `ADCP_PIN_RST;
         old_q     <= `ADCP_PIN_RST;
         d0_meta_q <= 1'b1;
         d0_sync_q <= 1'b1;
      end else begin
         meta_q    <= pins;
         sync_q    <= meta_q;
         old_q     <= sync_q;
         d0_meta_q <= ctrl_pin_0;
         d0_sync_q <= d0_meta_q;
      end
   end

   logic fs_hi, fs_lo, sel, p3, p2, p1, p1_rise, p2_rise;
   assign fs_hi   = sync_q[5];
   assign fs_lo   = sync_q[4];
   assign sel     = sync_q[3];
   assign p3      = sync_q[2];
   assign p2      = sync_q[1];
   assign p1      = sync_q[0];
   assign p1_rise = sync_q[0] & ~old_q[0];
   assign p2_rise = sync_q[1] & ~old_q[1];

   // Control method state
   adcp_mode_e st_q, st_d;
   always_comb begin
      case ({sel, p3})
         2'b00, 2'b01: st_d = ADCP_ST_STATIC;
         2'b10:        st_d = ADCP_ST_SERIAL;
         default:      st_d = ADCP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ADCP_ST_STATIC;
      end else begin
         st_q <= st_d;
      end
   end

   // Format decode; the bus format is accepted at the full 20 bits
   logic       rj_q, rj_d;
   logic [4:0] len_q, len_d;
   always_comb begin
      rj_d = fs_hi | fs_lo;
      case ({fs_hi, fs_lo})
         2'b00:   len_d = `ADCP_LEN_I2S;
         2'b01:   len_d = `ADCP_LEN_16;
         2'b10:   len_d = `ADCP_LEN_18;
         default: len_d = `ADCP_LEN_20;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rj_q  <= 1'b0;
         len_q <= `ADCP_LEN_I2S;
      end else begin
         rj_q  <= rj_d;
         len_q <= len_d;
      end
   end

   // Serial write port: shifter, register and pending command flag
   logic [7:0] sh_q, sh_d;
   logic [7:0] mode_q, mode_d;
   logic       pend_q, pend_d;
   logic       load;
   assign load = (st_q == ADCP_ST_SERIAL) && p2_rise && p1;

   // A strobe rising with the clock low falls through and changes nothing
   always_comb begin
      sh_d   = sh_q;
      mode_d = mode_q;
      pend_d = pend_q;
      if (st_q == ADCP_ST_SERIAL && !p2 && p1_rise) begin
         sh_d = {sh_q[6:0], d0_sync_q};
      end
      if (load) begin
         mode_d = {sh_q[7:1], 1'b0};
         pend_d = 1'b1;
      end else if (word_boundary) begin
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sh_q   <= 8'h00;
         mode_q <= `ADCP_MODE_RST;
         pend_q <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         mode_q <= mode_d;
         pend_q <= pend_d;
      end
   end

   // Level, speed and emphasis control
   adcp_fade_t fade_q, fade_d;
   logic       emph_q, emph_d;
   logic       dual_q, dual_d;
   adcp_fade_t tgt;
   always_comb begin
      fade_d = fade_q;
      emph_d = emph_q;
      dual_d = dual_q;
      tgt    = `ADCP_FADE_MAX;
      if (st_q == ADCP_ST_STATIC) begin
         dual_d = ~p1;
         if (!p2) begin
            tgt = `ADCP_FADE_MIN;
         end else if (!d0_sync_q) begin
            tgt = `ADCP_FADE_ATT;
         end
         // Static levels ramp one count per word to give a soft change
         if (word_boundary) begin
            emph_d = p3;
            if (fade_q < tgt) begin
               fade_d = fade_q + 7'h01;
            end else if (fade_q > tgt) begin
               fade_d = fade_q - 7'h01;
            end
         end
      end else if (st_q == ADCP_ST_SERIAL) begin
         dual_d = ~mode_q[`ADCP_B_DUAL_N];
         if (word_boundary && pend_q) begin
            emph_d = mode_q[`ADCP_B_EMPH];
            if (!mode_q[`ADCP_B_SIL_N]) begin
               fade_d = `ADCP_FADE_MIN;
            end else if (mode_q[`ADCP_B_FULL]) begin
               fade_d = `ADCP_FADE_MAX;
            end else if (!mode_q[`ADCP_B_ATT_N]) begin
               if (fade_q > `ADCP_FADE_ATT) begin
                  fade_d = `ADCP_FADE_ATT;
               end
            end else if (mode_q[`ADCP_B_UP] && fade_q < `ADCP_FADE_MAX) begin
               fade_d = fade_q + 7'h01;
            end else if (mode_q[`ADCP_B_DOWN] && fade_q > `ADCP_FADE_MIN) begin
               fade_d = fade_q - 7'h01;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fade_q <= `ADCP_FADE_MAX;
         emph_q <= 1'b0;
         dual_q <= 1'b0;
      end else begin
         fade_q <= fade_d;
         emph_q <= emph_d;
         dual_q <= dual_d;
      end
   end

   // Outputs straight from flip-flops; serial_active is decoded from the state register
   assign right_justified       = rj_q;
   assign word_bits             = len_q;
   assign dual_rate             = dual_q;
   assign emphasis_filter_on    = emph_q;
   assign fade_count            = fade_q;
   assign serial_active         = (st_q == ADCP_ST_SERIAL);
   assign playback_mode_control = mode_q;

   // Checks
   property p_fmt_len;
      @(posedge clk) disable iff (!rstn)
      ({fs_hi, fs_lo} == 2'b01) |=> (word_bits == 5'h10) && right_justified;
   endproperty
   a_fmt_len: assert property (p_fmt_len) else $error("format length wrong");

   property p_mode_sel;
      @(posedge clk) disable iff (!rstn)
      (sel && !p3) |=> serial_active;
   endproperty
   a_mode_sel: assert property (p_mode_sel) else $error("serial mode not taken");

   property p_load;
      @(posedge clk) disable iff (!rstn)
      load |=> playback_mode_control == {$past(sh_q[7:1]), 1'b0};
   endproperty
   a_load: assert property (p_load) else $error("register load wrong");

   property p_discard;
      @(posedge clk) disable iff (!rstn)
      (p2_rise && !p1) |=> $stable(playback_mode_control);
   endproperty
   a_discard: assert property (p_discard) else $error("command not discarded");

   property p_shift;
      @(posedge clk) disable iff (!rstn)
      (serial_active && !p2 && p1_rise) |=> sh_q == {$past(sh_q[6:0]), $past(d0_sync_q)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_rsvd;
      @(posedge clk) disable iff (!rstn)
      playback_mode_control[`ADCP_B_RSVD] == 1'b0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit stored");

   property p_range;
      @(posedge clk) disable iff (!rstn)
      fade_count <= 7'h78;
   endproperty
   a_range: assert property (p_range) else $error("fade out of range");

   property p_boundary;
      @(posedge clk) disable iff (!rstn)
      !$past(word_boundary) |-> $stable(fade_count) && $stable(emphasis_filter_on);
   endproperty
   a_boundary: assert property (p_boundary) else $error("change off boundary");

   property p_mute;
      @(posedge clk) disable iff (!rstn)
      (serial_active && word_boundary && pend_q && !mode_q[`ADCP_B_SIL_N])
         |=> fade_count == 7'h00;
   endproperty
   a_mute: assert property (p_mute) else $error("mute not applied");

   property p_speed;
      @(posedge clk) disable iff (!rstn)
      (st_q == ADCP_ST_STATIC) |=> dual_rate == !$past(p1);
   endproperty
   a_speed: assert property (p_speed) else $error("static speed wrong");

   property p_c_load;
      @(posedge clk) disable iff (!rstn) load ##[1:200] load;
   endproperty
   c_load: cover property (p_c_load);
   property p_c_mute;
      @(posedge clk) disable iff (!rstn) fade_count == 7'h00;
   endproperty
   c_mute: cover property (p_c_mute);
   property p_c_att;
      @(posedge clk) disable iff (!rstn) fade_count == 7'h1E;
   endproperty
   c_att: cover property (p_c_att);
endmodule
`default_nettype wire

// ==== sim/adcp_mcu_model.sv ====
// Controller and audio source model that drives the control pins
`timescale 1ns/1ns
`default_nettype none
module adcp_mcu_model (
   // System clock
   input  wire logic clk,
   // Serial control pins
   output logic      ser_data,
   output logic      ser_clk,
   output logic      ser_load,
   // Word marker of the audio receiver
   output logic      word_pulse
);
   // Shift clock parks high, as repeat pulses need it high between frames
   initial begin
      ser_data = 1'b0;
      ser_clk = 1'b1;
      ser_load = 1'b1;
      word_pulse = 1'b0;
   end
   // Half of the 80 ns shift clock period
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   // Shift 8 bits, or 9 when extra is set, then load with clock high or low
   task automatic send(input logic [8:0] val, input logic extra, input logic good);
      @(posedge clk);
      ser_load <= 1'b0;
      for (int i = extra ? 8 : 7; i >= 0; i--) begin
         ser_data <= val[i];
         ser_clk <= 1'b0;
         half();
         ser_clk <= 1'b1;
         half();
      end
      if (!good) begin
         ser_clk <= 1'b0;
         half();
      end
      ser_load <= 1'b1;
      half();
      ser_clk <= 1'b1;
      ser_data <= ~ser_data; // Released line shows no stale bit
      half();
   endtask
   // Strobe pulse with the clock held high repeats the last command
   task automatic pulse_again();
      @(posedge clk);
      ser_load <= 1'b0;
      half();
      ser_load <= 1'b1;
      half();
      half();
   endtask
   // One word boundary; 384 system clocks per sample, two channel words per sample
   task automatic word();
      @(posedge clk);
      word_pulse <= 1'b1;
      @(posedge clk);
      word_pulse <= 1'b0;
      repeat (190) @(posedge clk);
   endtask
   // Volume steps must lie 22 us apart: 2200 system clocks
   task automatic step_gap();
      repeat (2200) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench of the DAC control port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import adcp_pkg::*;
   logic       clk, rstn, fs_hi, fs_lo, sel, use_ser, p0, p1, p2, p3;
   logic       sd, sc, sl, wb, rj, dual, emph, sact;
   logic [4:0] wbits;
   logic [6:0] fade;
   logic [7:0] mreg, er;
   int         mismatches, checks_done;
   logic [7:0] cmds [9] = '{8'hC0, 8'hE8, 8'h60, 8'hE2, 8'hE2, 8'h60, 8'hE5, 8'hF0, 8'hA0};
   logic [7:0] fades [9] = '{8'h00, 8'h78, 8'h1E, 8'h1D, 8'h1C, 8'h1C, 8'h1D, 8'h1D, 8'h1D};
   // Serial pins come from the model while use_ser is set: serial mode and then idle mode
   adcp_top u_adcp_top (.clk(clk), .rstn(rstn), .format_select_hi(fs_hi),
      .format_select_lo(fs_lo), .interface_select(sel), .ctrl_pin_0(use_ser ? sd : p0),
      .ctrl_pin_1(use_ser ? sc : p1), .ctrl_pin_2(use_ser ? sl : p2), .ctrl_pin_3(p3),
      .word_boundary(wb), .right_justified(rj), .word_bits(wbits), .dual_rate(dual),
      .emphasis_filter_on(emph), .fade_count(fade), .serial_active(sact),
      .playback_mode_control(mreg));
   adcp_mcu_model u_adcp_mcu_model (.clk(clk), .ser_data(sd), .ser_clk(sc), .ser_load(sl),
      .word_pulse(wb));
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({7'h00, got}, {7'h00, exp});
   endtask
   task automatic test_done();
      $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // 100 MHz system clock, supplied from outside as the device is a clock slave
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Watchdog well beyond the expected run of some 104 us
   initial begin
      #500000;
      mismatches++;
      test_done();
   end
   initial begin
      {rstn, fs_hi, fs_lo, sel, use_ser, p3} = 6'b000000;
      {p0, p1, p2} = 3'b111;
      mismatches = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      chk_val(mreg, 8'hE0);
      chk_val({1'b0, fade}, 8'h78);
      chk_bit(sact, 1'b0);
      rstn <= 1'b1;
      for (int f = 0; f < 4; f++) begin
         fs_hi <= f[1];
         fs_lo <= f[0];
         repeat (5) @(posedge clk);
         chk_bit(rj, f != 0);
         chk_val({3'h0, wbits}, f == 1 ? 8'h10 : (f == 2 ? 8'h12 : 8'h14));
      end
      p1 <= 1'b0;
      repeat (5) @(posedge clk);
      chk_bit(dual, 1'b1);
      p1 <= 1'b1;
      p3 <= 1'b1;
      repeat (5) @(posedge clk);
      chk_bit(dual, 1'b0);
      chk_bit(emph, 1'b0);
      u_adcp_mcu_model.word();
      chk_bit(emph, 1'b1);
      p0 <= 1'b0;
      p2 <= 1'b0;
      repeat (5) @(posedge clk);
      repeat (3) u_adcp_mcu_model.word();
      chk_val({1'b0, fade}, 8'h75);
      p2 <= 1'b1;
      repeat (5) @(posedge clk);
      u_adcp_mcu_model.word();
      chk_val({1'b0, fade}, 8'h74);
      p0 <= 1'b1;
      p3 <= 1'b0;
      sel <= 1'b1;
      use_ser <= 1'b1;
      repeat (5) @(posedge clk);
      chk_bit(sact, 1'b1);
      // Step commands are spaced apart before they are sent or repeated
      for (int i = 0; i < 9; i++) begin
         if (cmds[i][2] | cmds[i][1]) u_adcp_mcu_model.step_gap();
         if (i == 4) u_adcp_mcu_model.pulse_again();
         else u_adcp_mcu_model.send({1'b0, cmds[i]}, 1'b0, 1'b1);
         er = {cmds[i][7:1], 1'b0};
         chk_val(mreg, er);
         u_adcp_mcu_model.word();
         chk_val({1'b0, fade}, fades[i]);
         if (i == 7) chk_bit(emph, 1'b1);
      end
      chk_bit(dual, 1'b1);
      chk_bit(emph, 1'b0);
      u_adcp_mcu_model.send(9'h0E8, 1'b1, 1'b1);
      chk_val(mreg, 8'hE8);
      u_adcp_mcu_model.send(9'h0C0, 1'b0, 1'b0);
      chk_val(mreg, 8'hE8);
      u_adcp_mcu_model.word();
      chk_val({1'b0, fade}, 8'h78);
      // Select high with pin 3 high is neither method: writes are ignored
      p3 <= 1'b1;
      repeat (5) @(posedge clk);
      chk_bit(sact, 1'b0);
      u_adcp_mcu_model.send(9'h060, 1'b0, 1'b1);
      chk_val(mreg, 8'hE8);
      test_done();
   end
endmodule
`default_nettype wire
